// ===== bench/cpu_instr_setbit_to_xor_test.sv
// cpu_instr_setbit_to_xor_test: program-driven bench for the execution core.
// assumes: program memory answers combinationally; sfr side modelled here.
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_setbit_to_xor_test;
  typedef logic [7:0] cpx_bq_t[$];
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] sfr_rdata_i = 8'h00;
  logic [7:0] pmem_data_i;
  logic [15:0] pmem_addr_o;
  logic [7:0] sfr_addr_o, sfr_wdata_o, acc_o, psw_o;
  logic sfr_rd_o, sfr_rmw_o, sfr_we_o, instr_done_o, unknown_op_o;
  logic [7:0] pmem [0:511];
  logic [7:0] w_addr = 8'h00;
  logic [7:0] w_data = 8'h00;
  int rmw_n = 0;
  int unk_n = 0;
  int num_errors = 0;
  int n_checks = 0;
  cpx_bq_t init_q = {8'h64, 8'h20, 8'hC5, 8'h00, 8'hC5, 8'hB0, 8'hC5, 8'h20, 8'hC5, 8'h90, 8'hD3};

  cpx_exec_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .pmem_addr_o(pmem_addr_o),
    .pmem_data_i(pmem_data_i), .sfr_addr_o(sfr_addr_o), .sfr_rd_o(sfr_rd_o),
    .sfr_rmw_o(sfr_rmw_o), .sfr_we_o(sfr_we_o), .sfr_wdata_o(sfr_wdata_o),
    .sfr_rdata_i(sfr_rdata_i), .acc_o(acc_o), .psw_o(psw_o),
    .instr_done_o(instr_done_o), .unknown_op_o(unknown_op_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  assign pmem_data_i = pmem[pmem_addr_o[8:0]];

  // sfr side: pins differ from the output latch so a latch read shows
  always @(posedge clk_i) begin
    if (sfr_rd_o) sfr_rdata_i <= sfr_rmw_o ? 8'h34 : (sfr_addr_o == 8'h90 ? 8'hC9 : 8'h54);
    else sfr_rdata_i <= ~sfr_rdata_i;
    if (sfr_we_o) begin
      w_addr <= sfr_addr_o;
      w_data <= sfr_wdata_o;
    end
    if (sfr_rmw_o) rmw_n <= rmw_n + 1;
    if (unknown_op_o === 1'b1) unk_n <= unk_n + 1;
  end

  task give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task load(input cpx_bq_t q);
    foreach (pmem[i]) pmem[i] = 8'h00;
    foreach (q[i]) pmem[i] = q[i];
  endtask

  task restart;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
  endtask

  // waits for the next done pulse, then checks length, acc and status
  task st(input int mc, input logic ca, input logic [7:0] ea, input logic [7:0] ep);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (instr_done_o !== 1'b1 && n < 16);
    chk(n == 4 * mc, "instruction length");
    if (ca) chk(acc_o === ea, "accumulator");
    chk(psw_o === ep, "status word");
  endtask

  // R0=20h, ram 20h=54h, acc=C9h, carry set
  task boot;
    restart;
    st(2, 1, 8'h20, 8'h00);
    st(2, 0, 8'h00, 8'h00);
    st(2, 1, 8'h54, 8'h00);
    st(2, 0, 8'h00, 8'h00);
    st(2, 1, 8'hC9, 8'h00);
    st(1, 1, 8'hC9, 8'h80);
  endtask

  task t_subtract_with_borrow_instr;
    load({init_q, 8'h96, 8'h95, 8'h20, 8'h94, 8'h21, 8'h98});
    boot;
    st(1, 1, 8'h74, 8'h04);
    st(2, 1, 8'h20, 8'h00);
    st(2, 1, 8'hFF, 8'hC0);
    st(1, 1, 8'hDE, 8'h00);
  endtask

  task t_digit;
    load({init_q, 8'hC4, 8'hD6, 8'hC6, 8'h65, 8'h20, 8'h66, 8'h68, 8'hC8, 8'h68});
    boot;
    st(1, 1, 8'h9C, 8'h80);
    st(1, 1, 8'h94, 8'h80);
    st(1, 1, 8'h5C, 8'h80);
    st(2, 1, 8'hC8, 8'h80);
    st(1, 1, 8'h5C, 8'h80);
    st(1, 1, 8'h7C, 8'h80);
    st(1, 1, 8'h20, 8'h80);
    st(1, 1, 8'h5C, 8'h80);
  endtask

  task t_xrl_port;
    int r0;
    int u0;
    load({8'hD3, 8'h63, 8'h90, 8'h31, 8'h64, 8'h0F, 8'h62, 8'h90, 8'hD2, 8'h90});
    restart;
    r0 = rmw_n;
    u0 = unk_n;
    st(1, 1, 8'h00, 8'h80);
    st(3, 1, 8'h00, 8'h80);
    chk(w_addr === 8'h90 && w_data === 8'h05, "xor imm to port");
    st(2, 1, 8'h0F, 8'h80);
    st(2, 1, 8'h0F, 8'h80);
    chk(w_addr === 8'h90 && w_data === 8'h3B, "xor acc to port");
    st(2, 1, 8'h0F, 8'h80);
    chk(w_addr === 8'h90 && w_data === 8'h35, "bit set on port");
    chk(rmw_n - r0 == 3, "latch read count");
    chk(unk_n == u0, "known opcode flagged unknown");
    st(1, 1, 8'h0F, 8'h80);
    chk(unk_n - u0 == 1, "unknown opcode not flagged");
    chk(pmem_addr_o === 16'h000B, "unknown opcode length");
  endtask

  task t_short_relative_jump_instr;
    load({8'h80, 8'h7E});
    pmem[9'h080] = 8'h80;
    pmem[9'h081] = 8'h7E;
    pmem[9'h100] = 8'h80;
    pmem[9'h101] = 8'h80;
    pmem[9'h082] = 8'h80;
    pmem[9'h083] = 8'h7F;
    pmem[9'h103] = 8'h80;
    pmem[9'h104] = 8'hFE;
    restart;
    st(3, 1, 8'h00, 8'h00);
    chk(pmem_addr_o === 16'h0080, "jump target");
    st(3, 1, 8'h00, 8'h00);
    chk(pmem_addr_o === 16'h0100, "jump target");
    st(3, 1, 8'h00, 8'h00);
    chk(pmem_addr_o === 16'h0082, "jump back");
    st(3, 1, 8'h00, 8'h00);
    chk(pmem_addr_o === 16'h0103, "jump forward");
    st(3, 1, 8'h00, 8'h00);
    chk(pmem_addr_o === 16'h0103, "jump to self");
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("MISMATCH at %0t: watchdog", $time);
    give_verdict;
  end

  initial begin
    t_subtract_with_borrow_instr;
    t_digit;
    t_xrl_port;
    t_short_relative_jump_instr;
    give_verdict;
  end
endmodule
`default_nettype wire

// ===== bench/cpx_exec_core_sva.sv
// cpx_exec_core_sva: port-level timing and result checks for the execution core.
// assumes: bound to cpx_exec_core; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cpx_exec_core_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] pmem_addr_o,
  input wire logic [7:0] pmem_data_i,
  input wire logic [7:0] sfr_addr_o,
  input wire logic sfr_rd_o,
  input wire logic sfr_rmw_o,
  input wire logic sfr_we_o,
  input wire logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i,
  input wire logic [7:0] acc_o,
  input wire logic [7:0] psw_o,
  input wire logic instr_done_o,
  input wire logic unknown_op_o
);
  wire logic [7:0] acc_swp;
  wire logic [15:0] rel_ext;
  wire logic ext_dir;
  assign acc_swp = {acc_o[3:0], acc_o[7:4]};
  assign rel_ext = {{8{pmem_data_i[7]}}, pmem_data_i};
  assign ext_dir = pmem_data_i[7] && pmem_data_i != cpx_pkg::ADDR_ACC
    && pmem_data_i != cpx_pkg::ADDR_PSW;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_done_pulse_gap: assert property (instr_done_o |=> !instr_done_o [*3])
    else $error("done pulses too close");
  a_rmw_with_read: assert property (sfr_rmw_o |-> sfr_rd_o)
    else $error("latch read without read strobe");
  a_xrl_latch_read: assert property ((instr_done_o && pmem_data_i == cpx_pkg::OP_XRL_DIR_IMM) ##1 ext_dir |-> sfr_rd_o && sfr_rmw_o && sfr_addr_o == pmem_data_i)
    else $error("xor to port did not read latch");
  a_xrl_port_write: assert property ((instr_done_o && pmem_data_i == cpx_pkg::OP_XRL_DIR_IMM) ##1 ext_dir |-> ##2 (sfr_we_o && sfr_wdata_o == ($past(sfr_rdata_i) ^ $past(pmem_data_i))))
    else $error("xor to port wrote wrong value");
  a_xrl_keeps_psw: assert property ((instr_done_o && pmem_data_i[7:4] == cpx_pkg::HI_XRL && pmem_data_i[3:2] != 2'b00) |=> $stable(psw_o) [*3])
    else $error("xor to acc changed status");
  a_swap_nibbles: assert property ((instr_done_o && pmem_data_i == cpx_pkg::OP_SWAP) |-> ##4 (instr_done_o && acc_o == $past(acc_swp, 4) && psw_o == $past(psw_o, 4)))
    else $error("nibble swap wrong");
  a_bit_force_one_instr_carry: assert property ((instr_done_o && pmem_data_i == cpx_pkg::OP_BIT_FORCE_ONE_INSTR_C) |-> ##4 (instr_done_o && psw_o == ($past(psw_o, 4) | 8'h80)))
    else $error("carry set wrong");
  a_short_relative_jump_instr_target: assert property ((instr_done_o && pmem_data_i == cpx_pkg::OP_SHORT_RELATIVE_JUMP_INSTR) |-> ##12 (instr_done_o && pmem_addr_o == 16'($past(pmem_addr_o, 12) + 16'h0002 + $past(rel_ext, 11))))
    else $error("short jump target wrong");
  a_acc_digit_exchange_instr_keeps_high: assert property ((instr_done_o && pmem_data_i[7:1] == cpx_pkg::OP_ACC_DIGIT_EXCHANGE_INSTR_TOP) |-> ##4 (instr_done_o && psw_o == $past(psw_o, 4) && (acc_o & 8'hF0) == ($past(acc_o, 4) & 8'hF0)))
    else $error("digit exchange touched high nibble or flags");
endmodule
bind cpx_exec_core cpx_exec_core_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .pmem_addr_o(pmem_addr_o), .pmem_data_i(pmem_data_i), .sfr_addr_o(sfr_addr_o),
  .sfr_rd_o(sfr_rd_o), .sfr_rmw_o(sfr_rmw_o), .sfr_we_o(sfr_we_o),
  .sfr_wdata_o(sfr_wdata_o), .sfr_rdata_i(sfr_rdata_i), .acc_o(acc_o), .psw_o(psw_o),
  .instr_done_o(instr_done_o), .unknown_op_o(unknown_op_o));
`default_nettype wire

// ===== rtl/cpx_alu.sv
// cpx_alu: subtract with borrow and its flags, byte exclusive-or.
// assumes: purely combinational, operands steady while used.
`timescale 1ns/1ps
`default_nettype none
module cpx_alu (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  input wire logic [7:0] xa_i,
  input wire logic [7:0] xb_i,
  output logic [7:0] diff_o,
  output logic c_o,
  output logic ac_o,
  output logic ov_o,
  output logic [7:0] xor_o
);

  logic [4:0] low4;
  logic [7:0] low7;
  logic [8:0] full;

  // a minus b minus carry, with the borrow out of each span
  assign low4 = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};
  assign low7 = {1'b0, a_i[6:0]} - {1'b0, b_i[6:0]} - {7'h00, cin_i};
  assign full = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
  assign diff_o = full[7:0];
  assign c_o = full[8];
  assign ac_o = low4[4];
  assign ov_o = low7[7] ^ full[8];
  assign xor_o = xa_i ^ xb_i;

endmodule
`default_nettype wire

// ===== rtl/cpx_exec_core.sv
// cpx_exec_core: fetch, operand access and execution for bit set, short jump,
// subtract with borrow, nibble swap, byte and digit exchange, exclusive-or.
// assumes: program memory answers combinationally on pmem_data_i; other sfrs
// answer one clock after sfr_rd_o, and give the output latch when sfr_rmw_o.
`timescale 1ns/1ps
`default_nettype none
module cpx_exec_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [15:0] pmem_addr_o,
  input wire logic [7:0] pmem_data_i,
  output logic [7:0] sfr_addr_o,
  output logic sfr_rd_o,
  output logic sfr_rmw_o,
  output logic sfr_we_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i,
  output logic [7:0] acc_o,
  output logic [7:0] psw_o,
  output logic instr_done_o,
  output logic unknown_op_o
);

  cpx_pkg::cpx_state_t state;
  cpx_pkg::cpx_state_t next_state;
  logic [15:0] pc;
  logic [7:0] acc;
  logic [7:0] psw;
  logic [7:0] opcode;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] opnd;
  logic [6:0] ptr;
  logic [7:0] last_rd;
  logic [1:0] phase;
  logic [1:0] mc_cnt;

  // machine cycle divider
  logic mc_tick;
  assign mc_tick = (phase == cpx_pkg::PHASE_LAST);

  // decode, from the bus during the opcode fetch and from the latch after
  logic [7:0] dop;
  logic [3:0] lo;
  logic f_rn;
  logic f_ri;
  logic f_dir;
  logic f_imm;
  logic is_subtract_with_borrow_instr;
  logic is_xrl_a;
  logic is_xrl_d;
  logic is_xrl_dimm;
  logic is_xch;
  logic is_swap;
  logic is_acc_digit_exchange_instr;
  logic is_setc;
  logic is_bit_force_one_instr;
  logic is_short_relative_jump_instr;
  logic arith;
  logic uses_reg;
  logic uses_ptr;
  logic needs_dir;
  logic two_plus;
  logic three_byte;
  logic known;
  logic [1:0] cycles_m1;

  assign dop = (state == cpx_pkg::S_OP) ? pmem_data_i : opcode;
  assign lo = dop[3:0];
  assign f_rn = dop[3];
  assign f_ri = (dop[3:1] == cpx_pkg::LO_IND_TOP);
  assign f_dir = (lo == cpx_pkg::LO_DIR);
  assign f_imm = (lo == cpx_pkg::LO_IMM);
  assign is_subtract_with_borrow_instr = (dop[7:4] == cpx_pkg::HI_SUBTRACT_WITH_BORROW_INSTR) && (lo >= cpx_pkg::LO_IMM);
  assign is_xrl_a = (dop[7:4] == cpx_pkg::HI_XRL) && (lo >= cpx_pkg::LO_IMM);
  assign is_xrl_dimm = (dop == cpx_pkg::OP_XRL_DIR_IMM);
  assign is_xrl_d = (dop == cpx_pkg::OP_XRL_DIR_A) || is_xrl_dimm;
  assign is_xch = (dop[7:4] == cpx_pkg::HI_XCH) && (lo >= cpx_pkg::LO_DIR);
  assign is_swap = (dop == cpx_pkg::OP_SWAP);
  assign is_acc_digit_exchange_instr = (dop[7:1] == cpx_pkg::OP_ACC_DIGIT_EXCHANGE_INSTR_TOP);
  assign is_setc = (dop == cpx_pkg::OP_BIT_FORCE_ONE_INSTR_C);
  assign is_bit_force_one_instr = (dop == cpx_pkg::OP_BIT_FORCE_ONE_INSTR_BIT);
  assign is_short_relative_jump_instr = (dop == cpx_pkg::OP_SHORT_RELATIVE_JUMP_INSTR);
  assign arith = is_subtract_with_borrow_instr || is_xrl_a || is_xch;
  assign uses_reg = (arith && (f_rn || f_ri)) || is_acc_digit_exchange_instr;
  assign uses_ptr = (arith && f_ri) || is_acc_digit_exchange_instr;
  assign needs_dir = (arith && f_dir) || is_xrl_d || is_bit_force_one_instr;
  assign three_byte = is_xrl_dimm;
  assign two_plus = three_byte || is_bit_force_one_instr || is_short_relative_jump_instr || is_xrl_d
                    || (arith && (f_dir || f_imm));
  assign known = arith || is_xrl_d || is_swap || is_acc_digit_exchange_instr || is_setc || is_bit_force_one_instr || is_short_relative_jump_instr;

  // machine cycles per form, less one
  assign cycles_m1 = (is_short_relative_jump_instr || three_byte) ? 2'h2 : (two_plus ? 2'h1 : 2'h0);

  // register bank addresses
  logic [7:0] reg_addr;
  logic [7:0] ptr_reg_addr;
  logic [7:0] rn_addr;
  assign rn_addr = {3'b000, psw[cpx_pkg::PSW_RS_HI:cpx_pkg::PSW_RS_LO], dop[2:0]};
  assign ptr_reg_addr = {3'b000, psw[cpx_pkg::PSW_RS_HI:cpx_pkg::PSW_RS_LO], 2'b00, dop[0]};
  assign reg_addr = uses_ptr ? ptr_reg_addr : rn_addr;

  // byte that holds a directly addressed bit
  logic [7:0] bit_src;
  logic [7:0] bit_byte;
  assign bit_src = (state == cpx_pkg::S_B1) ? pmem_data_i : b1;
  assign bit_byte = bit_src[7] ? {bit_src[7:3], 3'b000}
                               : {cpx_pkg::BIT_AREA_HI, 1'b0, bit_src[6:3]};

  // direct operand address
  logic [7:0] dir_addr;
  assign dir_addr = is_bit_force_one_instr ? bit_byte : bit_src;

  // read side
  logic [7:0] ram_rdata;
  logic [7:0] rd_addr;
  logic [7:0] rd_value;
  logic dir_internal;
  logic rd_ext;
  assign rd_addr = (state == cpx_pkg::S_OP) ? reg_addr
                 : (state == cpx_pkg::S_REG) ? {1'b0, ram_rdata[6:0]}
                 : dir_addr;
  assign dir_internal = (dir_addr == cpx_pkg::ADDR_ACC) || (dir_addr == cpx_pkg::ADDR_PSW);
  assign rd_ext = (state == cpx_pkg::S_B1) && needs_dir && dir_addr[7] && !dir_internal;
  assign rd_value = !last_rd[7] ? ram_rdata
                  : (last_rd == cpx_pkg::ADDR_ACC) ? acc
                  : (last_rd == cpx_pkg::ADDR_PSW) ? psw
                  : sfr_rdata_i;

  // arithmetic
  logic [7:0] diff;
  logic sub_c;
  logic sub_ac;
  logic sub_ov;
  logic [7:0] xor_res;
  logic [7:0] xor_b;
  assign xor_b = is_xrl_dimm ? b2 : acc;

  cpx_alu u_alu (
    .a_i(acc),
    .b_i(opnd),
    .cin_i(psw[cpx_pkg::PSW_C]),
    .xa_i(opnd),
    .xb_i(xor_b),
    .diff_o(diff),
    .c_o(sub_c),
    .ac_o(sub_ac),
    .ov_o(sub_ov),
    .xor_o(xor_res)
  );

  // write side, all in the execute step
  logic exe;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] bit_mask;
  logic wr_ram;
  logic wr_acc_dir;
  logic wr_psw_dir;
  logic wr_ext;
  assign exe = (state == cpx_pkg::S_EXE);
  assign wr_en = exe && (is_xch || is_acc_digit_exchange_instr || is_xrl_d || is_bit_force_one_instr);
  assign wr_addr = (uses_ptr) ? {1'b0, ptr}
                 : (is_xch && f_rn) ? rn_addr
                 : dir_addr;
  assign bit_mask = 8'h01 << b1[2:0];
  assign wr_data = is_xch ? acc
                 : is_acc_digit_exchange_instr ? {opnd[7:4], acc[3:0]}
                 : is_bit_force_one_instr ? (opnd | bit_mask)
                 : xor_res;
  assign wr_ram = wr_en && !wr_addr[7];
  assign wr_acc_dir = wr_en && (wr_addr == cpx_pkg::ADDR_ACC);
  assign wr_psw_dir = wr_en && (wr_addr == cpx_pkg::ADDR_PSW);
  assign wr_ext = wr_en && wr_addr[7] && !wr_acc_dir && !wr_psw_dir;

  cpx_iram u_iram (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .raddr_i(rd_addr[6:0]),
    .rdata_o(ram_rdata),
    .we_i(wr_ram),
    .waddr_i(wr_addr[6:0]),
    .wdata_i(wr_data)
  );

  // accumulator next value
  logic [7:0] next_acc;
  assign next_acc = wr_acc_dir ? wr_data
                  : !exe ? acc
                  : is_subtract_with_borrow_instr ? diff
                  : is_xrl_a ? xor_res
                  : is_xch ? opnd
                  : is_acc_digit_exchange_instr ? {acc[7:4], opnd[3:0]}
                  : is_swap ? {acc[3:0], acc[7:4]}
                  : acc;

  // status word next value; swap, exchange and xor fall through untouched unless their direct address is the status word
  logic [7:0] psw_sub;
  logic [7:0] next_psw;
  assign psw_sub = {sub_c, sub_ac, psw[5:3], sub_ov, psw[1:0]};
  assign next_psw = wr_psw_dir ? wr_data
                  : !exe ? psw
                  : is_subtract_with_borrow_instr ? psw_sub
                  : is_setc ? (psw | (8'h01 << cpx_pkg::PSW_C))
                  : psw;

  // instruction finishes on the last machine cycle of its listed count
  logic fin;
  assign fin = mc_tick && (mc_cnt == cycles_m1)
               && ((state == cpx_pkg::S_EXE) || (state == cpx_pkg::S_HOLD));

  // jump target: pc already advanced by two in fetch
  logic [15:0] jump_pc;
  assign jump_pc = pc + {{8{b1[7]}}, b1};

  logic fetch;
  assign fetch = (state == cpx_pkg::S_OP) || (state == cpx_pkg::S_B1)
                 || (state == cpx_pkg::S_B2);

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      cpx_pkg::S_OP: begin
        if (uses_reg) begin
          next_state = cpx_pkg::S_REG;
        end else if (two_plus) begin
          next_state = cpx_pkg::S_B1;
        end else begin
          next_state = cpx_pkg::S_EXE;
        end
      end
      cpx_pkg::S_REG: begin
        next_state = uses_ptr ? cpx_pkg::S_IND : cpx_pkg::S_EXE;
      end
      cpx_pkg::S_IND: begin
        next_state = cpx_pkg::S_EXE;
      end
      cpx_pkg::S_B1: begin
        if (three_byte) begin
          next_state = cpx_pkg::S_B2;
        end else if (needs_dir) begin
          next_state = cpx_pkg::S_DIR;
        end else begin
          next_state = cpx_pkg::S_EXE;
        end
      end
      cpx_pkg::S_B2: begin
        next_state = cpx_pkg::S_EXE;
      end
      cpx_pkg::S_DIR: begin
        next_state = cpx_pkg::S_EXE;
      end
      cpx_pkg::S_EXE: begin
        next_state = fin ? cpx_pkg::S_OP : cpx_pkg::S_HOLD;
      end
      cpx_pkg::S_HOLD: begin
        next_state = fin ? cpx_pkg::S_OP : cpx_pkg::S_HOLD;
      end
      default: begin
        next_state = cpx_pkg::S_OP;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= cpx_pkg::S_OP;
      phase <= 2'h0;
      mc_cnt <= 2'h0;
    end else begin
      state <= next_state;
      phase <= phase + 2'h1;
      if (mc_tick) begin
        mc_cnt <= fin ? 2'h0 : mc_cnt + 2'h1;
      end
    end
  end

  // instruction bytes and operand capture
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      opcode <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      opnd <= 8'h00;
      ptr <= 7'h00;
      last_rd <= 8'h00;
    end else begin
      last_rd <= rd_addr;
      if (state == cpx_pkg::S_OP) begin
        opcode <= pmem_data_i;
      end
      if (state == cpx_pkg::S_B1) begin
        b1 <= pmem_data_i;
        opnd <= pmem_data_i;
      end
      if (state == cpx_pkg::S_B2) begin
        b2 <= pmem_data_i;
        opnd <= rd_value;
      end
      if (state == cpx_pkg::S_REG) begin
        ptr <= ram_rdata[6:0];
        opnd <= ram_rdata;
      end
      if ((state == cpx_pkg::S_IND) || (state == cpx_pkg::S_DIR)) begin
        opnd <= rd_value;
      end
    end
  end

  // architectural registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc <= cpx_pkg::ACC_RST;
      psw <= cpx_pkg::PSW_RST;
    end else begin
      acc <= next_acc;
      psw <= next_psw;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc <= cpx_pkg::PC_RST;
    end else if (exe && is_short_relative_jump_instr) begin
      pc <= jump_pc;
    end else if (fetch) begin
      pc <= pc + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      instr_done_o <= 1'b0;
      unknown_op_o <= 1'b0;
    end else begin
      instr_done_o <= fin;
      unknown_op_o <= exe && !known;
    end
  end

  assign pmem_addr_o = pc;
  assign acc_o = acc;
  assign psw_o = psw;
  assign sfr_addr_o = exe ? wr_addr : dir_addr;
  assign sfr_rd_o = rd_ext;
  assign sfr_rmw_o = rd_ext && (is_xrl_d || is_bit_force_one_instr);
  assign sfr_we_o = wr_ext;
  assign sfr_wdata_o = wr_data;

endmodule
`default_nettype wire

// ===== rtl/cpx_iram.sv
// cpx_iram: internal data ram, one write port and one read port.
// assumes: read data appear one clock after the address, from a register.
`timescale 1ns/1ps
`default_nettype none
module cpx_iram #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // a write and a read to one byte in the same clock return the new byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (we_i && waddr_i == raddr_i) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cpx_pkg.sv
// cpx_pkg: opcodes, special register addresses, field positions, reset values
// and machine cycle timing for the bit-set to exclusive-or execution group.
// assumes: an 8-bit core with 128 bytes of internal ram and 16-bit pc.
package cpx_pkg;

  // timing
  localparam int CLK_HZ = 25000000;
  localparam int CLKS_PER_MC = 4;
  localparam logic [1:0] PHASE_LAST = 2'(CLKS_PER_MC - 1);

  // opcodes
  localparam logic [7:0] OP_SHORT_RELATIVE_JUMP_INSTR = 8'h80;
  localparam logic [7:0] OP_BIT_FORCE_ONE_INSTR_C = 8'hD3;
  localparam logic [7:0] OP_BIT_FORCE_ONE_INSTR_BIT = 8'hD2;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_XRL_DIR_A = 8'h62;
  localparam logic [7:0] OP_XRL_DIR_IMM = 8'h63;
  localparam logic [3:0] HI_SUBTRACT_WITH_BORROW_INSTR = 4'h9;
  localparam logic [3:0] HI_XRL = 4'h6;
  localparam logic [3:0] HI_XCH = 4'hC;
  localparam logic [6:0] OP_ACC_DIGIT_EXCHANGE_INSTR_TOP = 7'h6B;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [2:0] LO_IND_TOP = 3'h3;

  // directly addressed registers held inside the core
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [2:0] BIT_AREA_HI = 3'h1;

  // status word fields
  localparam int PSW_C = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;

  // sequencer states
  typedef enum logic [2:0] {
    S_OP, S_REG, S_IND, S_B1, S_B2, S_DIR, S_EXE, S_HOLD
  } cpx_state_t;

endpackage
